/* File: rtl/iosc_pkg.sv */
// Package of constants and types for the I/O sampling and sleep control block.
package iosc_pkg;

  // ---------------------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_W = 17;
  localparam int unsigned PWM_STEP_MS = 100;
  localparam int unsigned SP_UNIT_MS = 10;
  localparam int unsigned DISCARD_NUM = 5;
  localparam int unsigned DISCARD_DEN = 2;
  localparam int unsigned CHECK_MS = 2;
  localparam int unsigned TMR_W = 26;
  localparam int unsigned DEST_W = 32;

  // ---------------------------------------------------------------------------
  // Parameter selectors on the command port
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SEL_PWM_EXPIRY = 4'h0;
  localparam logic [3:0] SEL_ANALOG_REF = 4'h1;
  localparam logic [3:0] SEL_CHANGE_MASK = 4'h2;
  localparam logic [3:0] SEL_SAMPLE_DIV = 4'h3;
  localparam logic [3:0] SEL_SAMPLE_INTERVAL = 4'h4;
  localparam logic [3:0] SEL_TEMPERATURE = 4'h5;
  localparam logic [3:0] SEL_SLEEP_MODE = 4'h6;
  localparam logic [3:0] SEL_SLEEP_OPTIONS = 4'h7;
  localparam logic [3:0] SEL_PERIODS_PER_IND = 4'h8;
  localparam logic [3:0] SEL_SLEEP_PERIOD = 4'h9;
  localparam logic [3:0] SEL_FORCE_SAMPLE = 4'hA;

  // ---------------------------------------------------------------------------
  // Reset values, limits and fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PWM_EXPIRY_RST = 8'h28;
  localparam logic [7:0] PWM_FOREVER = 8'hFF;
  localparam logic [7:0] SAMPLE_DIV_RST = 8'h01;
  localparam logic [15:0] SLEEP_OPTIONS_RST = 16'h0002;
  localparam logic [15:0] PERIODS_PER_IND_RST = 16'h0001;
  localparam logic [20:0] SLEEP_PERIOD_RST = 21'h00012C;
  localparam logic [31:0] MAX_8 = 32'h000000FF;
  localparam logic [31:0] MAX_16 = 32'h0000FFFF;
  localparam logic [31:0] SLEEP_PERIOD_MAX = 32'd1440000;
  localparam int unsigned OPT_FORCE_COORD = 0;
  localparam int unsigned OPT_NO_COORD = 1;
  localparam int unsigned OPT_FULL_WAKE = 8;
  localparam int unsigned NUM_DIO = 13;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0000,
    MODE_PIN = 4'b0001,
    MODE_ASYNC = 4'b0100,
    MODE_ASYNC_PIN = 4'b0101,
    MODE_SUPPORT = 4'b0111,
    MODE_SYNC = 4'b1000
  } iosc_mode_e;

  typedef enum logic [1:0] {
    PH_AWAKE = 2'b00,
    PH_SLEEP = 2'b01,
    PH_CHECK = 2'b10,
    PH_WAKE = 2'b11
  } iosc_phase_e;

endpackage : iosc_pkg

/* File: rtl/iosc_io_sleep_ctrl.sv */
// I/O sampling, change detection, signal-strength PWM expiry and sleep sequencing.

module iosc_io_sleep_ctrl #(
  parameter int unsigned MS_CYCLES = iosc_pkg::MS_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] cmd_sel_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic resp_valid_o,
  output logic resp_err_o,
  output logic [31:0] resp_data_o,
  input wire logic rssi_update_i,
  output logic rssi_pwm_en_o,
  output logic analog_ref_sel_o,
  input wire logic [12:0] dio_i,
  input wire logic [12:0] dio_digital_i,
  input wire logic any_input_en_i,
  input wire logic api_mode_setting_i,
  input wire logic [iosc_pkg::DEST_W-1:0] destination_address_i,
  output logic sample_req_o,
  output logic sample_change_o,
  output logic [iosc_pkg::DEST_W-1:0] sample_dest_o,
  output logic forced_sample_o,
  output logic forced_api_o,
  output logic forced_ok_o,
  input wire logic [7:0] temp_sensor_i,
  input wire logic sleep_request_line_i,
  input wire logic rx_data_i,
  input wire logic [21:0] wake_time_i,
  input wire logic indirect_coord_i,
  input wire logic msg_held_i,
  output logic msg_discard_o,
  output logic sleeping_o,
  output logic on_sleep_o,
  output logic [15:0] sleep_options_o
);
  import iosc_pkg::*;

  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic mode_legal(input logic [31:0] v);
    mode_legal = (v == 32'(MODE_NORMAL)) || (v == 32'(MODE_PIN)) || (v == 32'(MODE_ASYNC)) ||
                 (v == 32'(MODE_ASYNC_PIN)) || (v == 32'(MODE_SUPPORT)) || (v == 32'(MODE_SYNC));
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0] pwm_expiry_time;
  logic analog_reference_select;
  logic [15:0] change_detect_mask;
  logic [7:0] sleep_sample_divider;
  logic [15:0] sample_interval;
  logic [7:0] board_temperature;
  iosc_mode_e sleep_mode_select;
  logic [15:0] sleep_options;
  logic [15:0] sleep_periods_per_indication;
  logic [20:0] sleep_period;

  wire logic cmd_wr = cmd_valid_i && cmd_write_i;
  wire logic [31:0] wd = cmd_wdata_i;
  wire logic opts_ok = in_range(wd, 32'h0, MAX_16) && !(wd[OPT_FORCE_COORD] && wd[OPT_NO_COORD]);
  // Illegal values are refused whole, keeping settings legal.
  wire logic wr_ok =
    (cmd_sel_i == SEL_PWM_EXPIRY) ? in_range(wd, 32'h0, MAX_8) :
    (cmd_sel_i == SEL_ANALOG_REF) ? in_range(wd, 32'h0, 32'h1) :
    (cmd_sel_i == SEL_CHANGE_MASK) ? in_range(wd, 32'h0, MAX_16) :
    (cmd_sel_i == SEL_SAMPLE_DIV) ? in_range(wd, 32'h1, MAX_8) :
    (cmd_sel_i == SEL_SAMPLE_INTERVAL) ? in_range(wd, 32'h0, MAX_16) :
    (cmd_sel_i == SEL_SLEEP_MODE) ? mode_legal(wd) :
    (cmd_sel_i == SEL_SLEEP_OPTIONS) ? opts_ok :
    (cmd_sel_i == SEL_PERIODS_PER_IND) ? in_range(wd, 32'h1, MAX_16) :
    (cmd_sel_i == SEL_SLEEP_PERIOD) ? in_range(wd, 32'h1, SLEEP_PERIOD_MAX) :
    1'b0;
  wire logic sel_known = cmd_sel_i <= SEL_FORCE_SAMPLE;
  wire logic cmd_bad = !sel_known || (cmd_write_i && (cmd_sel_i != SEL_FORCE_SAMPLE) && !wr_ok);
  wire logic wr_en = cmd_wr && wr_ok;
  wire logic force_cmd = cmd_valid_i && (cmd_sel_i == SEL_FORCE_SAMPLE);

  wire logic [31:0] rd_data =
    (cmd_sel_i == SEL_PWM_EXPIRY) ? 32'(pwm_expiry_time) :
    (cmd_sel_i == SEL_ANALOG_REF) ? 32'(analog_reference_select) :
    (cmd_sel_i == SEL_CHANGE_MASK) ? 32'(change_detect_mask) :
    (cmd_sel_i == SEL_SAMPLE_DIV) ? 32'(sleep_sample_divider) :
    (cmd_sel_i == SEL_SAMPLE_INTERVAL) ? 32'(sample_interval) :
    (cmd_sel_i == SEL_TEMPERATURE) ? 32'(board_temperature) :
    (cmd_sel_i == SEL_SLEEP_MODE) ? 32'(sleep_mode_select) :
    (cmd_sel_i == SEL_SLEEP_OPTIONS) ? 32'(sleep_options) :
    (cmd_sel_i == SEL_PERIODS_PER_IND) ? 32'(sleep_periods_per_indication) :
    (cmd_sel_i == SEL_SLEEP_PERIOD) ? 32'(sleep_period) :
    '0;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pwm_expiry_time <= PWM_EXPIRY_RST;
      analog_reference_select <= 1'b0;
      change_detect_mask <= 16'h0000;
      sleep_sample_divider <= SAMPLE_DIV_RST;
      sample_interval <= 16'h0000;
      sleep_mode_select <= MODE_NORMAL;
      sleep_options <= SLEEP_OPTIONS_RST;
      sleep_periods_per_indication <= PERIODS_PER_IND_RST;
      sleep_period <= SLEEP_PERIOD_RST;
    end else if (wr_en) begin
      unique case (cmd_sel_i)
        SEL_PWM_EXPIRY: pwm_expiry_time <= wd[7:0];
        SEL_ANALOG_REF: analog_reference_select <= wd[0];
        SEL_CHANGE_MASK: change_detect_mask <= wd[15:0];
        SEL_SAMPLE_DIV: sleep_sample_divider <= wd[7:0];
        SEL_SAMPLE_INTERVAL: sample_interval <= wd[15:0];
        SEL_SLEEP_MODE: sleep_mode_select <= iosc_mode_e'(wd[3:0]);
        SEL_SLEEP_OPTIONS: sleep_options <= wd[15:0];
        SEL_PERIODS_PER_IND: sleep_periods_per_indication <= wd[15:0];
        SEL_SLEEP_PERIOD: sleep_period <= wd[20:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      resp_valid_o <= 1'b0;
      resp_err_o <= 1'b0;
      resp_data_o <= '0;
      board_temperature <= 8'h00;
    end else begin
      resp_valid_o <= cmd_valid_i;
      resp_err_o <= cmd_valid_i && cmd_bad;
      resp_data_o <= (cmd_valid_i && !cmd_write_i) ? rd_data : '0;
      board_temperature <= temp_sensor_i;
    end
  end

  assign analog_ref_sel_o = analog_reference_select;
  assign sleep_options_o = sleep_options;

  // ---------------------------------------------------------------------------
  // Millisecond timebase
  // ---------------------------------------------------------------------------
  logic [MS_W-1:0] ms_cnt;
  wire logic ms_tick = ms_cnt == MS_LAST;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Signal-strength PWM expiry
  // ---------------------------------------------------------------------------
  logic [15:0] pwm_left;
  wire logic pwm_forever = pwm_expiry_time == PWM_FOREVER;
  wire logic [15:0] pwm_load = 16'(pwm_expiry_time * PWM_STEP_MS);
  wire logic [15:0] next_pwm_left = rssi_update_i ? pwm_load :
                                    (ms_tick && pwm_left != 16'h0000) ? pwm_left - 16'h0001 : pwm_left;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pwm_left <= 16'h0000;
      rssi_pwm_en_o <= 1'b0;
    end else begin
      pwm_left <= next_pwm_left;
      rssi_pwm_en_o <= pwm_forever || next_pwm_left != 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers and change detection
  // ---------------------------------------------------------------------------
  logic [12:0] dio_meta;
  logic [12:0] dio_sync;
  logic [12:0] dio_prev;
  logic rq_meta;
  logic rq_sync;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dio_meta <= 13'h0000;
      dio_sync <= 13'h0000;
      dio_prev <= 13'h0000;
      rq_meta <= 1'b0;
      rq_sync <= 1'b0;
    end else begin
      dio_meta <= dio_i;
      dio_sync <= dio_meta;
      rq_meta <= sleep_request_line_i;
      rq_sync <= rq_meta;
      if (ms_tick) begin
        dio_prev <= dio_sync;
      end
    end
  end

  // Unimplemented mask bits are ignored so they cannot fire.
  wire logic [12:0] dio_watch = change_detect_mask[NUM_DIO-1:0] & dio_digital_i;
  wire logic dio_changed = ms_tick && ((dio_sync ^ dio_prev) & dio_watch) != 13'h0000;

  // ---------------------------------------------------------------------------
  // Sleep sequencer
  // ---------------------------------------------------------------------------
  iosc_phase_e phase;
  iosc_phase_e next_phase;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [15:0] per_cnt;
  logic [15:0] next_per_cnt;
  logic [7:0] wake_cnt;
  logic sample_sel;

  wire logic mode_pin = sleep_mode_select == MODE_PIN;
  wire logic cyclic = (sleep_mode_select == MODE_ASYNC) || (sleep_mode_select == MODE_SYNC) ||
                      ((sleep_mode_select == MODE_ASYNC_PIN) && rq_sync);
  wire logic [TMR_W-1:0] sleep_ms = TMR_W'(sleep_period * SP_UNIT_MS);
  wire logic [TMR_W-1:0] wake_ms = TMR_W'(wake_time_i);
  wire logic tmr_done = ms_tick && tmr <= TMR_W'(1);
  wire logic [TMR_W-1:0] tmr_dec = (ms_tick && tmr != '0) ? tmr - TMR_W'(1) : tmr;
  // Sync sleep and the full-wake option make every wake full.
  wire logic ind_due = (per_cnt + 16'h0001 >= sleep_periods_per_indication) ||
                       (sleep_mode_select == MODE_SYNC) || sleep_options[OPT_FULL_WAKE];
  wire logic enter_wake = (next_phase == PH_WAKE) && (phase != PH_WAKE);

  always_comb begin
    next_phase = phase;
    next_tmr = tmr_dec;
    next_per_cnt = per_cnt;
    unique case (phase)
      PH_AWAKE: begin
        if (mode_pin && rq_sync) begin
          next_phase = PH_SLEEP;
        end else if (cyclic) begin
          next_phase = PH_SLEEP;
          next_tmr = sleep_ms;
        end
      end
      PH_SLEEP: begin
        if (mode_pin) begin
          next_phase = rq_sync ? PH_SLEEP : PH_AWAKE;
        end else if (!cyclic) begin
          next_phase = PH_AWAKE;
        end else if (tmr_done) begin
          if (ind_due) begin
            next_phase = PH_WAKE;
            next_tmr = wake_ms;
            next_per_cnt = 16'h0000;
          end else begin
            next_phase = PH_CHECK;
            next_tmr = TMR_W'(CHECK_MS);
            next_per_cnt = per_cnt + 16'h0001;
          end
        end
      end
      PH_CHECK: begin
        if (!cyclic) begin
          next_phase = PH_AWAKE;
        end else if (rx_data_i) begin
          next_phase = PH_WAKE;
          next_tmr = wake_ms;
        end else if (tmr_done) begin
          next_phase = PH_SLEEP;
          next_tmr = sleep_ms;
        end
      end
      PH_WAKE: begin
        if (!cyclic) begin
          next_phase = PH_AWAKE;
        end else if (rx_data_i) begin
          next_tmr = wake_ms;
        end else if (tmr_done) begin
          next_phase = PH_SLEEP;
          next_tmr = sleep_ms;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      phase <= PH_AWAKE;
      tmr <= '0;
      per_cnt <= 16'h0000;
      wake_cnt <= 8'h00;
      sample_sel <= 1'b0;
      sleeping_o <= 1'b0;
      on_sleep_o <= 1'b1;
    end else begin
      phase <= next_phase;
      tmr <= next_tmr;
      per_cnt <= next_per_cnt;
      sleeping_o <= next_phase == PH_SLEEP;
      on_sleep_o <= (next_phase == PH_AWAKE) || (next_phase == PH_WAKE);
      if (enter_wake) begin
        // Counting wakes lets the sampler skip all but every Nth.
        if (wake_cnt + 8'h01 >= sleep_sample_divider) begin
          wake_cnt <= 8'h00;
          sample_sel <= 1'b1;
        end else begin
          wake_cnt <= wake_cnt + 8'h01;
          sample_sel <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Periodic, change-driven and forced samples
  // ---------------------------------------------------------------------------
  logic [15:0] ivl_cnt;
  wire logic awake_ok = (phase == PH_AWAKE) || ((phase == PH_WAKE) && sample_sel);
  wire logic periodic_on = (sample_interval != 16'h0000) && any_input_en_i && awake_ok;
  wire logic ivl_hit = ms_tick && (ivl_cnt + 16'h0001 >= sample_interval);
  wire logic periodic_fire = periodic_on && ivl_hit;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ivl_cnt <= 16'h0000;
      sample_req_o <= 1'b0;
      sample_change_o <= 1'b0;
      sample_dest_o <= '0;
      forced_sample_o <= 1'b0;
      forced_api_o <= 1'b0;
      forced_ok_o <= 1'b0;
    end else begin
      if (!periodic_on) begin
        ivl_cnt <= 16'h0000;
      end else if (ms_tick) begin
        ivl_cnt <= ivl_hit ? 16'h0000 : ivl_cnt + 16'h0001;
      end
      sample_req_o <= periodic_fire || dio_changed;
      sample_change_o <= dio_changed;
      if (periodic_fire || dio_changed) begin
        sample_dest_o <= destination_address_i;
      end
      forced_sample_o <= force_cmd;
      forced_api_o <= force_cmd && api_mode_setting_i;
      forced_ok_o <= force_cmd && api_mode_setting_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Indirect message hold limit
  // ---------------------------------------------------------------------------
  logic [TMR_W-1:0] hold_cnt;
  wire logic hold_on = indirect_coord_i && msg_held_i && (sleep_period != 21'h000000);
  wire logic [TMR_W-1:0] hold_limit = TMR_W'((sleep_period * SP_UNIT_MS * DISCARD_NUM) / DISCARD_DEN);
  wire logic hold_expired = hold_on && ms_tick && (hold_cnt + TMR_W'(1) >= hold_limit);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hold_cnt <= '0;
      msg_discard_o <= 1'b0;
    end else begin
      if (!hold_on || hold_expired) begin
        hold_cnt <= '0;
      end else if (ms_tick) begin
        hold_cnt <= hold_cnt + TMR_W'(1);
      end
      msg_discard_o <= hold_expired;
    end
  end

endmodule // iosc_io_sleep_ctrl

/* File: dv/iosc_io_sleep_ctrl_properties.sv */
// Port-level assertion checker for the I/O sampling and sleep control block.
module iosc_io_sleep_ctrl_properties
  import iosc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] cmd_sel_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic resp_err_o,
  input wire logic rssi_update_i,
  input wire logic rssi_pwm_en_o,
  input wire logic analog_ref_sel_o,
  input wire logic api_mode_setting_i,
  input wire logic [DEST_W-1:0] destination_address_i,
  input wire logic sample_req_o,
  input wire logic sample_change_o,
  input wire logic [DEST_W-1:0] sample_dest_o,
  input wire logic forced_sample_o,
  input wire logic forced_api_o,
  input wire logic forced_ok_o,
  input wire logic sleep_request_line_i,
  input wire logic sleeping_o
);
  // ---------------------------------------------------------------------------
  // Shadow settings
  // ---------------------------------------------------------------------------
  // The shadow follows legal writes only.
  logic [7:0] expiry_q;
  logic [3:0] mode_q;
  wire logic wr_cmd = cmd_valid_i && cmd_write_i;
  wire logic mode_ok = cmd_wdata_i inside {32'h0, 32'h1, 32'h4, 32'h5, 32'h7, 32'h8};
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      expiry_q <= PWM_EXPIRY_RST;
      mode_q <= 4'h0;
    end else begin
      if (wr_cmd && cmd_sel_i == SEL_PWM_EXPIRY && cmd_wdata_i <= MAX_8) expiry_q <= cmd_wdata_i[7:0];
      if (wr_cmd && cmd_sel_i == SEL_SLEEP_MODE && mode_ok) mode_q <= cmd_wdata_i[3:0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_PWM_START: assert property (rssi_update_i && !cmd_valid_i && expiry_q != 8'h00 |=> rssi_pwm_en_o)
    else $error("pwm not started");
  AST_PWM_HOLD: assert property (expiry_q == PWM_FOREVER && rssi_pwm_en_o && !cmd_valid_i |=> rssi_pwm_en_o)
    else $error("pwm stopped");
  AST_REF_SEL: assert property (wr_cmd && cmd_sel_i == SEL_ANALOG_REF && cmd_wdata_i <= 32'h1
    |=> {31'h0, analog_ref_sel_o} == $past(cmd_wdata_i) && !resp_err_o) else $error("reference select wrong");
  AST_CHANGE_REQ: assert property (sample_change_o |-> sample_req_o)
    else $error("change without request");
  AST_DEST: assert property (sample_req_o |-> sample_dest_o == $past(destination_address_i))
    else $error("destination wrong");
  AST_FORCED: assert property (cmd_valid_i && cmd_sel_i == SEL_FORCE_SAMPLE |=> forced_sample_o
    && forced_api_o == $past(api_mode_setting_i) && forced_ok_o == forced_api_o) else $error("forced sample wrong");
  AST_TEMP_RO: assert property (wr_cmd && cmd_sel_i == SEL_TEMPERATURE |=> resp_err_o)
    else $error("temperature write accepted");
  AST_MODE_SET: assert property (wr_cmd && cmd_sel_i == SEL_SLEEP_MODE |=> resp_err_o == !$past(mode_ok))
    else $error("mode legality wrong");
  AST_OPT_PAIR: assert property (wr_cmd && cmd_sel_i == SEL_SLEEP_OPTIONS && cmd_wdata_i[1:0] == 2'h3
    |=> resp_err_o) else $error("option pair accepted");
  AST_PIN_SLEEP: assert property ((mode_q == MODE_PIN && sleep_request_line_i) [*4] |=> sleeping_o)
    else $error("pin sleep missed");
  AST_PIN_WAKE: assert property ((mode_q inside {MODE_PIN, MODE_ASYNC_PIN} && !sleep_request_line_i) [*4]
    |=> !sleeping_o) else $error("asleep after release");
endmodule // iosc_io_sleep_ctrl_properties

bind iosc_io_sleep_ctrl iosc_io_sleep_ctrl_properties iosc_io_sleep_ctrl_properties_i (.*);

/* File: dv/iosc_host_model.sv */
// Host model that issues parameter commands to the block one at a time.
module iosc_host_model
  import iosc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resp_valid_i,
  input wire logic resp_err_i,
  input wire logic [31:0] resp_data_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [3:0] cmd_sel_o,
  output logic [31:0] cmd_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_sel_o = 4'h0;
    cmd_wdata_o = '0;
  end
  // Bad lets a test break the option pairing on purpose.
  task automatic xfer(input logic w, input logic [3:0] s, input logic [31:0] d, input logic bad,
                      output logic err, output logic [31:0] rd, output logic hung);
    logic [31:0] v;
    v = d;
    if (w && s == SEL_CHANGE_MASK) v = d & 32'h1FFF;
    if (w && s == SEL_SLEEP_OPTIONS && !bad && v[1:0] == 2'h3) v[0] = 1'b0;
    @(posedge ref_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_sel_o = s;
    cmd_wdata_o = v;
    @(posedge ref_clk_i);
    #1;
    hung = resp_valid_i !== 1'b1;
    err = resp_err_i;
    rd = resp_data_i;
    // Released data is inverted so it cannot look valid.
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~v;
  endtask
endmodule // iosc_host_model

/* File: dv/tb.sv */
// Self-checking testbench for the I/O sampling and sleep control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iosc_pkg::*;
  localparam int unsigned MSC = 10;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rssi_update = 1'b0, any_in = 1'b0, api_mode = 1'b0, sleep_request_line = 1'b0, coord = 1'b0, held = 1'b0, rx = 1'b0;
  logic [12:0] dio = 13'h0000;
  logic [7:0] temp = 8'hF6;
  logic [31:0] dest = 32'h00000000;
  logic cmd_valid, cmd_write, resp_valid, resp_err, pwm_en, ref_sel, s_req, s_chg, f_smp, f_api, f_ok;
  logic discard, sleeping, on_sleep, herr, hung;
  logic [3:0] cmd_sel;
  logic [31:0] cmd_wdata, resp_data, s_dest, rd;
  logic [15:0] s_opt;
  logic [31:0] mdl [10];
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'h6A92;
  int c;
  always #5 ref_clk_i = ~ref_clk_i;
  iosc_host_model iosc_host_model_i (.ref_clk_i(ref_clk_i), .resp_valid_i(resp_valid), .resp_err_i(resp_err),
    .resp_data_i(resp_data), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_sel_o(cmd_sel),
    .cmd_wdata_o(cmd_wdata));
  iosc_io_sleep_ctrl #(.MS_CYCLES(MSC)) iosc_io_sleep_ctrl_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_sel_i(cmd_sel), .cmd_wdata_i(cmd_wdata),
    .resp_valid_o(resp_valid), .resp_err_o(resp_err), .resp_data_o(resp_data), .rssi_update_i(rssi_update),
    .rssi_pwm_en_o(pwm_en), .analog_ref_sel_o(ref_sel), .dio_i(dio), .dio_digital_i(13'h1FFF),
    .any_input_en_i(any_in), .api_mode_setting_i(api_mode), .destination_address_i(dest), .sample_req_o(s_req),
    .sample_change_o(s_chg), .sample_dest_o(s_dest), .forced_sample_o(f_smp), .forced_api_o(f_api),
    .forced_ok_o(f_ok), .temp_sensor_i(temp), .sleep_request_line_i(sleep_request_line), .rx_data_i(rx),
    .wake_time_i(22'h000003), .indirect_coord_i(coord), .msg_held_i(held), .msg_discard_o(discard),
    .sleeping_o(sleeping), .on_sleep_o(on_sleep), .sleep_options_o(s_opt));
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic legal(input int s, input logic [31:0] v);
    case (s)
      0: return v <= 32'hFF;
      1: return v <= 32'h1;
      2, 4: return v <= 32'hFFFF;
      3: return v >= 32'h1 && v <= 32'hFF;
      6: return v inside {32'h0, 32'h1, 32'h4, 32'h5, 32'h7, 32'h8};
      7: return v <= 32'hFFFF && v[1:0] != 2'h3;
      8: return v >= 32'h1 && v <= 32'hFFFF;
      9: return v >= 32'h1 && v <= 32'h15F900;
      default: return 1'b0;
    endcase
  endfunction
  task automatic host(input logic w, input int s, input logic [31:0] v, input logic bad);
    iosc_host_model_i.xfer(w, s[3:0], v, bad, herr, rd, hung);
    if (hung) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic wrc(input int s, input logic [31:0] v, input logic bad = 1'b0);
    host(1'b1, s, v, bad);
    chk1(herr, !legal(s, v));
    if (legal(s, v)) mdl[s] = v;
  endtask
  task automatic rdc(input int s);
    host(1'b0, s, 32'h0, 1'b0);
    chk(s == 5 ? {24'h000000, rd[7:0]} : rd, mdl[s]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return pwm_en;
      1: return s_req;
      2: return sleeping;
      default: return discard;
    endcase
  endfunction
  // A wait that runs out counts a mismatch and ends the run.
  task automatic wait_lvl(input int w, input logic l, input int n);
    for (c = 0; c < n && sig(w) !== l; c++) tick(1);
    chk1(sig(w), l);
    if (sig(w) !== l) report_and_stop();
  endtask
  task automatic count_req(input int n);
    c = 0;
    repeat (n) begin
      tick(1);
      if (s_req === 1'b1) c++;
    end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    mdl = '{32'h28, 32'h0, 32'h0, 32'h1, 32'h0, 32'hF6, 32'h0, 32'h2, 32'h1, 32'h12C};
    tick(12);
    resetn_i = 1'b1;
    for (int s = 0; s < 10; s++) rdc(s);
    chk(32'(s_opt), 32'h2);
    $display("reset test done");
    for (int i = 0; i < 16; i++) wrc(6, i);
    wrc(6, 32'h0);
    wrc(7, 32'h3, 1'b1);
    wrc(7, 32'h13C);
    chk(32'(s_opt), 32'h13C);
    wrc(5, 32'h7);
    wrc(11, 32'h0);
    foreach (mdl[i]) wrc(i == 5 ? 0 : i, i == 5 ? 32'h100 : 32'h0);
    wrc(3, 32'hFF);
    wrc(8, 32'hFFFF);
    wrc(9, 32'h15F901);
    wrc(9, 32'h15F900);
    wrc(2, 32'($random(seed)) & 32'h00001FFF);
    wrc(1, 32'h1);
    chk1(ref_sel, 1'b1);
    temp = 8'($random(seed));
    tick(3);
    mdl[5] = {24'h000000, temp};
    for (int s = 0; s < 10; s++) rdc(s);
    $display("register test done");
    wrc(0, 32'h1);
    rssi_update = 1'b1;
    tick(1);
    rssi_update = 1'b0;
    chk1(pwm_en, 1'b1);
    tick(940);
    wait_lvl(0, 1'b0, 80);
    chk1(c >= 45 && c <= 65, 1'b1);
    wrc(0, 32'hFF);
    rssi_update = 1'b1;
    tick(1);
    rssi_update = 1'b0;
    tick(2600);
    chk1(pwm_en, 1'b1);
    $display("pwm test done");
    wrc(4, 32'h0);
    wrc(2, 32'h8);
    dio[3] = ~dio[3];
    wait_lvl(1, 1'b1, 40);
    chk1(s_chg, 1'b1);
    dio[4] = ~dio[4];
    count_req(40);
    chk(32'(c), 32'h0);
    $display("change test done");
    any_in = 1'b1;
    dest = 32'($random(seed));
    wrc(4, 32'h5);
    wait_lvl(1, 1'b1, 70);
    count_req(200);
    chk(32'(c), 32'h4);
    chk(s_dest, dest);
    wrc(4, 32'h0);
    count_req(100);
    chk(32'(c), 32'h0);
    $display("periodic test done");
    for (int a = 0; a < 2; a++) begin
      api_mode = a[0];
      host(1'b0, 10, 32'h0, 1'b0);
      chk({29'h0, f_smp, f_api, f_ok}, {29'h0, 1'b1, a[0], a[0]});
    end
    $display("forced test done");
    wrc(9, 32'h1);
    wrc(6, 32'h1);
    sleep_request_line = 1'b1;
    tick(5);
    chk1(sleeping, 1'b1);
    sleep_request_line = 1'b0;
    tick(5);
    chk1(sleeping, 1'b0);
    wrc(6, 32'h5);
    sleep_request_line = 1'b1;
    wait_lvl(2, 1'b1, 150);
    sleep_request_line = 1'b0;
    tick(4);
    chk1(sleeping, 1'b0);
    tick(300);
    chk1(sleeping, 1'b0);
    wrc(8, 32'h1);
    wrc(6, 32'h4);
    wait_lvl(2, 1'b1, 150);
    wait_lvl(2, 1'b0, 150);
    chk1(c >= 91 && c <= 100, 1'b1);
    chk1(on_sleep, 1'b1);
    wait_lvl(2, 1'b1, 45);
    wrc(8, 32'h2);
    wait_lvl(2, 1'b0, 150);
    chk1(on_sleep, 1'b0);
    rx = 1'b1;
    tick(2);
    chk1(on_sleep, 1'b1);
    rx = 1'b0;
    $display("sleep test done");
    wrc(6, 32'h0);
    coord = 1'b1;
    held = 1'b1;
    wait_lvl(3, 1'b1, 265);
    chk1(c >= 235, 1'b1);
    $display("discard test done");
    report_and_stop();
  end
endmodule // tb
